// ---- rtl/ufsa_user_flash.sv ----
// User flash block with serial address/data port, busy handshake,
// an alternate test-port register path and an oscillator clock output.
// Assumes fabric pins are asynchronous; they are synchronised here.
// Notes on behaviour
// - Oscillator divided by four offered as clock.
// - Oscillator rate fixed, no adjust control.
// - Internal engine is timed by oscillator.
// - Request runs full program/erase algorithm.
// - Busy stays high until operation finishes.
// - Test-port path also reads and programs.
// - Single read and stream read supported.
// - Select low: each rising clock edge increments address.
// - Address nine bits, data sixteen bits.
// - Inputs accept global clock or routing.
`timescale 1ns/1ns
module ufsa_user_flash
  import ufsa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input ufsa_pkg::ufsa_serial_t ser_i,
  output logic data_sout_o,
  output logic busy_o,
  output logic ring_clock_out_o,
  input wire logic [3:0] tp_addr_i,
  input wire logic [15:0] tp_wdata_i,
  input wire logic tp_wr_i,
  input wire logic tp_rd_i,
  output logic [15:0] tp_rdata_o
);
  import ufsa_pkg::*;
  ufsa_serial_t s1_reg, s2_reg, s3_reg;
  logic [UFSA_ADDR_W-1:0] addr_reg;
  logic [UFSA_DATA_W-1:0] data_reg;
  logic [UFSA_DATA_W-1:0] mem [UFSA_DEPTH];
  ufsa_state_t state_reg;
  logic [11:0] cnt_reg;
  logic tick, ring_clk;
  logic ar_edge, dr_edge;
  logic tp_prog, tp_erase, tp_read;
  logic [UFSA_DATA_W-1:0] tp_wdata_reg;
  logic op_read, op_prog, op_erase;
  logic [UFSA_DATA_W-1:0] fetched_reg;
  // Rising edge of a synchronised clock-like input
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rise
  ufsa_ring_osc u_osc (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ring_clock_out_o(ring_clk),
    .tick_o(tick)
  );
  // Two-stage sync of fabric inputs, global or routed alike; third stage for edges
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= ser_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign ar_edge = rise(s2_reg.addr_reg_clock, s3_reg.addr_reg_clock);
  assign dr_edge = rise(s2_reg.data_reg_clock, s3_reg.data_reg_clock);
  // Test-port command decode
  assign tp_prog = tp_wr_i && tp_addr_i == UFSA_OFS_CTRL && tp_wdata_i[UFSA_CTL_PROG];
  assign tp_erase = tp_wr_i && tp_addr_i == UFSA_OFS_CTRL && tp_wdata_i[UFSA_CTL_ERASE];
  assign tp_read = tp_wr_i && tp_addr_i == UFSA_OFS_CTRL && tp_wdata_i[UFSA_CTL_READ];
  // Operation start: serial port or test port, only from idle
  assign op_prog = state_reg == UFSA_IDLE && (s2_reg.program_req || tp_prog);
  assign op_erase = state_reg == UFSA_IDLE && !op_prog && (s2_reg.erase_req || tp_erase);
  assign op_read = state_reg == UFSA_IDLE && tp_read;
  // Address register: shift when selected, else increment per edge
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      addr_reg <= UFSA_ADDR_RST;
    else if (tp_wr_i && tp_addr_i == UFSA_OFS_ADDR)
      addr_reg <= tp_wdata_i[UFSA_ADDR_W-1:0];
    else if (ar_edge && s2_reg.addr_load_shift_select)
      addr_reg <= {addr_reg[UFSA_ADDR_W-2:0], s2_reg.addr_sin};
    else if (ar_edge)
      addr_reg <= addr_reg + 9'h001;
  end
  // Data register: shift in/out, or parallel load from the array
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      data_reg <= '0;
      data_sout_o <= 1'b0;
    end
    else
    begin
      if (dr_edge && s2_reg.data_shift_select)
        data_reg <= {data_reg[UFSA_DATA_W-2:0], s2_reg.data_sin};
      else if (dr_edge)
        data_reg <= mem[addr_reg];
      else if (tp_wr_i && tp_addr_i == UFSA_OFS_WDATA)
        data_reg <= tp_wdata_i;
      data_sout_o <= data_reg[UFSA_DATA_W-1];
    end
  end
  // Engine sequenced by oscillator ticks
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= UFSA_IDLE;
      cnt_reg <= 12'h000;
      busy_o <= 1'b0;
    end
    else
    begin
      case (state_reg)
        UFSA_IDLE:
        begin
          if (op_prog)
          begin
            state_reg <= UFSA_PROG;
            cnt_reg <= 12'(UFSA_PROG_TICKS);
            busy_o <= 1'b1;
          end
          else if (op_erase)
          begin
            state_reg <= UFSA_ERASE;
            cnt_reg <= 12'(UFSA_ERASE_TICKS);
            busy_o <= 1'b1;
          end
          else if (op_read)
          begin
            state_reg <= UFSA_READ;
            cnt_reg <= 12'(UFSA_READ_TICKS);
            busy_o <= 1'b1;
          end
        end
        UFSA_READ, UFSA_PROG, UFSA_ERASE:
        begin
          if (tick)
          begin
            if (cnt_reg == 12'h001)
              state_reg <= UFSA_DONE;
            cnt_reg <= cnt_reg - 12'h001;
          end
        end
        UFSA_DONE:
        begin
          busy_o <= 1'b0;
          // Wait for requests to drop so a held request is not rerun
          if (!s2_reg.program_req && !s2_reg.erase_req)
            state_reg <= UFSA_IDLE;
        end
        default:
          state_reg <= UFSA_IDLE;
      endcase
    end
  end
  // Array update at the end of an algorithm
  always_ff @(posedge core_clk_i)
  begin
    if (state_reg == UFSA_PROG && tick && cnt_reg == 12'h001)
      mem[addr_reg] <= mem[addr_reg] & data_reg;
    else if (state_reg == UFSA_ERASE && tick && cnt_reg == 12'h001)
      for (int i = 0; i < UFSA_DEPTH; i++)
        mem[i] <= UFSA_ERASED;
  end
  // Test-port read capture
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      fetched_reg <= '0;
    else if (state_reg == UFSA_READ && tick && cnt_reg == 12'h001)
      fetched_reg <= mem[addr_reg];
  end
  // Test-port read data, one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tp_rdata_o <= '0;
    else if (tp_rd_i)
    begin
      case (tp_addr_i)
        UFSA_OFS_ADDR: tp_rdata_o <= {7'h00, addr_reg};
        UFSA_OFS_WDATA: tp_rdata_o <= data_reg;
        UFSA_OFS_RDATA: tp_rdata_o <= fetched_reg;
        UFSA_OFS_STAT: tp_rdata_o <= {13'h0000, state_reg};
        default: tp_rdata_o <= 16'h0000;
      endcase
    end
    else
      tp_rdata_o <= 16'h0000;
  end
  // Oscillator clock out, registered
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ring_clock_out_o <= 1'b0;
    else
      ring_clock_out_o <= ring_clk;
  end
  // Busy holds while engine is in the program or erase state
  AST_BUSY_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (state_reg == UFSA_PROG || state_reg == UFSA_ERASE) |=> busy_o)
    else $error("busy low during operation");
  AST_START_BUSY: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    op_prog |=> busy_o && state_reg == UFSA_PROG)
    else $error("program request did not start");
  AST_INC: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ar_edge && !s2_reg.addr_load_shift_select && !(tp_wr_i && tp_addr_i == UFSA_OFS_ADDR)
    |=> addr_reg == $past(addr_reg) + 9'h001)
    else $error("address did not increment");
  AST_SHIFT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ar_edge && s2_reg.addr_load_shift_select && !(tp_wr_i && tp_addr_i == UFSA_OFS_ADDR)
    |=> addr_reg[0] == $past(s2_reg.addr_sin))
    else $error("address bit not shifted");
  // Busy must fall on the cycle after the engine reaches done
  AST_DONE_BUSY_LOW: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_reg == UFSA_DONE |=> !busy_o)
    else $error("busy still high after operation end");
  // Test-port read data is zero outside the cycle after a read strobe
  AST_RDATA_IDLE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !tp_rd_i |=> tp_rdata_o == 16'h0000)
    else $error("read data not idle without strobe");
endmodule : ufsa_user_flash

// ---- shared/ufsa_pkg.sv ----
// Package for the user flash serial access block: widths, timing, states.
// Assumes a single 25 MHz core clock and plain-port register access.
package ufsa_pkg;
  // Shift register widths
  localparam int UFSA_ADDR_W = 9;
  localparam int UFSA_DATA_W = 16;
  localparam int UFSA_DEPTH = 512;
  // Ring oscillator model: core cycles per half period of the raw ring
  localparam int UFSA_CORE_MHZ = 25;
  localparam int UFSA_RING_MHZ = 18;
  localparam int UFSA_RING_HALF = (UFSA_CORE_MHZ + 2 * UFSA_RING_MHZ - 1) / (2 * UFSA_RING_MHZ);
  localparam int UFSA_DIV = 4;
  // Algorithm lengths in undivided ring ticks, one per rising ring edge
  localparam int UFSA_PROG_US = 100;
  localparam int UFSA_ERASE_US = 500;
  localparam int UFSA_PROG_TICKS = (UFSA_PROG_US * 4) / 1;
  localparam int UFSA_ERASE_TICKS = (UFSA_ERASE_US * 4) / 1;
  localparam int UFSA_READ_TICKS = 2;
  localparam logic [15:0] UFSA_ERASED = 16'hFFFF;
  localparam logic [8:0] UFSA_ADDR_RST = 9'h000;
  // Register offsets on the plain port
  localparam logic [3:0] UFSA_OFS_CTRL = 4'h0;
  localparam logic [3:0] UFSA_OFS_ADDR = 4'h1;
  localparam logic [3:0] UFSA_OFS_WDATA = 4'h2;
  localparam logic [3:0] UFSA_OFS_RDATA = 4'h3;
  localparam logic [3:0] UFSA_OFS_STAT = 4'h4;
  // Control field positions
  localparam int UFSA_CTL_PROG = 0;
  localparam int UFSA_CTL_ERASE = 1;
  localparam int UFSA_CTL_READ = 2;
  // Engine states
  typedef enum logic [2:0] {
    UFSA_IDLE = 3'b000,
    UFSA_READ = 3'b001,
    UFSA_PROG = 3'b010,
    UFSA_ERASE = 3'b011,
    UFSA_DONE = 3'b100
  } ufsa_state_t;
  // Serial port bundle from fabric
  typedef struct packed {
    logic addr_reg_clock;
    logic addr_load_shift_select;
    logic addr_sin;
    logic data_reg_clock;
    logic data_shift_select;
    logic data_sin;
    logic program_req;
    logic erase_req;
  } ufsa_serial_t;
endpackage : ufsa_pkg

// ---- rtl/ufsa_ring_osc.sv ----
// Ring oscillator model, divide-by-four clock output and per-rising-edge tick generator.
// Assumes core_clk_i runs at least twice the modeled ring rate.
`timescale 1ns/1ns
module ufsa_ring_osc
  import ufsa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  output logic ring_clock_out_o,
  output logic tick_o
);
  logic [3:0] half_reg;
  logic ring_reg;
  logic [1:0] div_reg;
  // Raw ring toggling, fixed rate with no control
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      half_reg <= 4'h0;
      ring_reg <= 1'b0;
    end
    else if (half_reg == 4'(UFSA_RING_HALF - 1))
    begin
      half_reg <= 4'h0;
      ring_reg <= ~ring_reg;
    end
    else
      half_reg <= half_reg + 4'h1;
  end
  // Divide by four; tick marks each rising ring edge for the engine
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_reg <= 2'h0;
      ring_clock_out_o <= 1'b0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (half_reg == 4'(UFSA_RING_HALF - 1) && !ring_reg)
      begin
        div_reg <= div_reg + 2'h1;
        tick_o <= 1'b1;
        if (div_reg[0])
          ring_clock_out_o <= ~ring_clock_out_o;
      end
    end
  end
endmodule : ufsa_ring_osc

// ---- testbench/ufsa_fabric_model.sv ----
// Fabric-side logic model: drives the serial address port and flash requests.
// Assumes the bench clock; every signal changes right after a rising edge.
`timescale 1ns/1ns
module ufsa_fabric_model
  import ufsa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic busy_i,
  output ufsa_pkg::ufsa_serial_t ser_o,
  output logic timeout_o
);
  // Quiet port at time zero, address clock stands still
  initial
  begin
    ser_o = '0;
    timeout_o = 1'b0;
  end
  // One slow rise and fall of the address clock
  task automatic pulse_clk();
    repeat (4) @(posedge core_clk_i);
    ser_o.addr_reg_clock <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    ser_o.addr_reg_clock <= 1'b0;
  endtask : pulse_clk
  // Nine address bits, MSB first, with select high
  task automatic shift_addr(input logic [8:0] a);
    @(posedge core_clk_i);
    ser_o.addr_load_shift_select <= 1'b1;
    for (int i = UFSA_ADDR_W - 1; i >= 0; i--)
    begin
      ser_o.addr_sin <= a[i];
      pulse_clk();
    end
    repeat (4) @(posedge core_clk_i);
    ser_o.addr_load_shift_select <= 1'b0;
    ser_o.addr_sin <= ~a[0];
  endtask : shift_addr
  // Select low: clock edges step the address
  task automatic bump(input int n);
    repeat (n) pulse_clk();
  endtask : bump
  // Request held until busy falls, then dropped
  task automatic req_op(input logic erase);
    int k;
    @(posedge core_clk_i);
    if (erase) ser_o.erase_req <= 1'b1;
    else ser_o.program_req <= 1'b1;
    for (k = 0; k < 40 && !busy_i; k++) @(posedge core_clk_i);
    if (k == 40) timeout_o <= 1'b1;
    for (k = 0; k < 40000 && busy_i; k++) @(posedge core_clk_i);
    if (k == 40000) timeout_o <= 1'b1;
    ser_o.erase_req <= 1'b0;
    ser_o.program_req <= 1'b0;
  endtask : req_op
  // One data clock pulse: select low loads the array word, high shifts one bit
  task automatic pulse_data(input logic sel, input logic din);
    @(posedge core_clk_i);
    ser_o.data_shift_select <= sel;
    ser_o.data_sin <= din;
    repeat (4) @(posedge core_clk_i);
    ser_o.data_reg_clock <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    ser_o.data_reg_clock <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    ser_o.data_shift_select <= 1'b0;
  endtask : pulse_data
endmodule : ufsa_fabric_model

// ---- testbench/user_flash_serial_access_bench.sv ----
// Self-checking bench: fabric model on the serial port, test port by tasks.
// Assumes the flash package constants and a 25 MHz core clock.
`timescale 1ns/1ns
module user_flash_serial_access_bench;
  import ufsa_pkg::*;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  ufsa_serial_t ser;
  logic data_sout, busy, ring, tmo, tp_wr = 1'b0, tp_rd = 1'b0;
  logic [3:0] tp_addr = 4'h0;
  logic [15:0] tp_wdata = 16'h0000, tp_rdata, d;
  logic [8:0] a;
  int errors = 0, checked = 0, mem[UFSA_DEPTH], p1, p2, n;
  ufsa_user_flash dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ser_i(ser),
    .data_sout_o(data_sout), .busy_o(busy), .ring_clock_out_o(ring),
    .tp_addr_i(tp_addr), .tp_wdata_i(tp_wdata), .tp_wr_i(tp_wr), .tp_rd_i(tp_rd),
    .tp_rdata_o(tp_rdata));
  ufsa_fabric_model fab (.core_clk_i(core_clk_i), .busy_i(busy), .ser_o(ser),
    .timeout_o(tmo));
  // Clock, 40 ns period
  initial
  begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [3:0] ad, input logic [15:0] v);
    @(posedge core_clk_i);
    tp_wr <= 1'b1;
    tp_addr <= ad;
    tp_wdata <= v;
    @(posedge core_clk_i);
    tp_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [15:0] v);
    @(posedge core_clk_i);
    tp_rd <= 1'b1;
    tp_addr <= ad;
    @(posedge core_clk_i);
    tp_rd <= 1'b0;
    #1 v = tp_rdata;
  endtask : rd
  // Test-port operation; returns the busy cycle count
  task automatic op(input int b, output int cnt);
    int k;
    wr(UFSA_OFS_CTRL, 16'h0001 << b);
    for (k = 0; k < 40 && busy !== 1'b1; k++) @(posedge core_clk_i);
    for (cnt = 0; cnt < 40000 && busy === 1'b1; cnt++) @(posedge core_clk_i);
    if (k == 40 || cnt == 40000)
    begin
      errors++;
      results();
    end
    wr(UFSA_OFS_CTRL, 16'h0000);
    repeat (4) @(posedge core_clk_i);
  endtask : op
  task automatic period(output int p);
    for (p = 0; p < 200 && ring !== 1'b0; p++) @(posedge core_clk_i);
    for (p = 0; p < 200 && ring !== 1'b1; p++) @(posedge core_clk_i);
    for (p = 1; p < 200 && ring !== 1'b0; p++) @(posedge core_clk_i);
    for (; p < 200 && ring !== 1'b1; p++) @(posedge core_clk_i);
  endtask : period
  // Main sequence
  initial
  begin
    void'($urandom(91));
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rd(4'hF, d);
    check(d, 16'h0000);
    period(p1);
    period(p2);
    check(16'(p1), 16'(p2));
    check(16'(p1 >= 2 * UFSA_DIV), 16'h0001);
    foreach (mem[i]) mem[i] = 32'hFFFF;
    for (int t = 0; t < 2; t++)
    begin
      a = t ? 9'h1FF : 9'($urandom);
      fab.shift_addr(a);
      repeat (6) @(posedge core_clk_i);
      rd(UFSA_OFS_ADDR, d);
      check(d, {7'h00, a});
      fab.bump(3);
      repeat (6) @(posedge core_clk_i);
      rd(UFSA_OFS_ADDR, d);
      check(d, {7'h00, 9'(a + 9'd3)});
    end
    fab.req_op(1'b1);
    check({15'h0000, tmo}, 16'h0000);
    repeat (8) @(posedge core_clk_i);
    check({15'h0000, busy}, 16'h0000);
    for (int t = 0; t < 3; t++)
    begin
      a = 9'($urandom);
      d = 16'($urandom);
      mem[a] = mem[a] & int'(d);
      wr(UFSA_OFS_ADDR, {7'h00, a});
      wr(UFSA_OFS_WDATA, d);
      op(UFSA_CTL_PROG, n);
      check(16'(n >= UFSA_PROG_TICKS), 16'h0001);
      for (int j = 0; j < 2; j++)
      begin
        wr(UFSA_OFS_ADDR, {7'h00, 9'(a + 9'(j))});
        op(UFSA_CTL_READ, n);
        rd(UFSA_OFS_RDATA, d);
        check(d, 16'(mem[9'(a + 9'(j))]));
      end
    end
    // Serial data path: load the word at the shifted address, then shift in a one
    fab.shift_addr(a);
    fab.pulse_data(1'b0, 1'b0);
    repeat (4) @(posedge core_clk_i);
    rd(UFSA_OFS_WDATA, d);
    check(d, 16'(mem[a]));
    check({15'h0000, data_sout}, 16'(mem[a] >> 15));
    fab.pulse_data(1'b1, 1'b1);
    repeat (4) @(posedge core_clk_i);
    rd(UFSA_OFS_WDATA, d);
    check(d, 16'((mem[a] << 1) | 1));
    check({15'h0000, data_sout}, 16'(mem[a] >> 14));
    results();
  end
endmodule : user_flash_serial_access_bench
